// ### inc/obcd_consts.svh
// Function
// - Standby-run bit 1 keeps the watchdog counting in HALT or STOP.
// - Standby-run bit 0 forces a 100% window open period.
// - Overflow select codes 000..111 give 2^6,7,8,9,11,13,14,16 slow cycles.
// - Detector mode 10 is interrupt-and-reset with a threshold pair and lower reset.
// - Mode 11 is reset-only, 01 interrupt-only, with a single threshold pair.
// - Top group bit 1 with mode bit 0 set turns detection off.
// - Flash mode 00 low-voltage, 10 low-speed, 11 high-speed; 01 prohibited.
// - Frequency select codes map to 32 down to 1 MHz; others prohibited.
// - Debug enable/erase bits: 00 off, 10 on with erase, 11 on; 01 prohibited.
// - Active debug may overwrite debug byte bits 3 to 1.
// - Boot swap fetches the four bytes from 010C0H instead of 000C0H.
// - Window bits select 50% (01), 75% (10), 100% (11); 00 prohibited.
// - Interval interrupt fires at 75% of overflow plus half a slow cycle.
// - Counter-run bit 1 starts counting after reset; 0 keeps it stopped.
// - Standby-run bit 0 stops the watchdog counter in HALT or STOP.
`ifndef OBCD_CONSTS_SVH
`define OBCD_CONSTS_SVH
`define OBCD_IDX_WD 8'hC0
`define OBCD_IDX_LVD 8'hC1
`define OBCD_IDX_FOSC 8'hC2
`define OBCD_IDX_DBG 8'hC3
`define OBCD_IDX_STAT 8'hC4
`define OBCD_IDX_CTRL 8'hC5
`define OBCD_BASE_NORMAL 20'h000C0
`define OBCD_BASE_SWAP 20'h010C0
`define OBCD_LAST_BYTE 2'h3
`define OBCD_BYTE_RST 8'h00
`define OBCD_CTRL_RST 1'b0
`define OBCD_WD_IRQ_BIT 7
`define OBCD_WD_WIN_HI 6
`define OBCD_WD_WIN_LO 5
`define OBCD_WD_RUN_BIT 4
`define OBCD_WD_OVF_HI 3
`define OBCD_WD_OVF_LO 1
`define OBCD_WD_STBY_BIT 0
`define OBCD_LVD_GRP_HI 7
`define OBCD_LVD_GRP_LO 5
`define OBCD_LVD_FIX_BIT 4
`define OBCD_LVD_LVL_HI 3
`define OBCD_LVD_LVL_LO 2
`define OBCD_LVD_MODE_HI 1
`define OBCD_LVD_MODE_LO 0
`define OBCD_FM_MODE_HI 7
`define OBCD_FM_MODE_LO 6
`define OBCD_FM_ONE_BIT 5
`define OBCD_FM_ZERO_BIT 4
`define OBCD_FM_FRQ_HI 3
`define OBCD_FM_FRQ_LO 0
`define OBCD_DBG_EN_BIT 7
`define OBCD_DBG_KEEP_BIT 0
`define OBCD_DBG_FIX_HI 6
`define OBCD_DBG_FIX_LO 4
`define OBCD_DBG_OVR_HI 3
`define OBCD_DBG_OVR_LO 1
`define OBCD_STAT_READY_BIT 8
`define OBCD_RESP_OKAY 2'h0
`define OBCD_RESP_DECERR 2'h3
`endif

// ### inc/obcd_pkg.sv
package obcd_pkg;
   typedef enum logic [1:0] {
      OBCD_LVD_OFF = 2'b00,
      OBCD_LVD_IRQ = 2'b01,
      OBCD_LVD_RST = 2'b10,
      OBCD_LVD_IRQ_RST = 2'b11
   } obcd_lvd_mode_t;
   typedef enum logic [1:0] {
      OBCD_LOW_VOLTAGE_MAIN = 2'b00,
      OBCD_LOW_SPEED_MAIN = 2'b01,
      OBCD_HIGH_SPEED_MAIN = 2'b10,
      OBCD_FLASH_MODE_BAD = 2'b11
   } obcd_flash_mode_t;
   typedef enum logic [1:0] {
      OBCD_F_SWAP = 2'b00,
      OBCD_F_READ = 2'b01,
      OBCD_F_DONE = 2'b10
   } obcd_fetch_st_t;
   typedef struct packed {
      logic counter_run;
      logic standby_run;
      logic interval_irq_use;
      logic [6:0] open_pct;
      logic [4:0] ovf_exp;
      logic [16:0] ovf_cycles;
      logic [16:0] irq_cycles;
   } obcd_wd_cfg_t;
   typedef struct packed {
      obcd_lvd_mode_t mode;
      logic [11:0] rise_mv;
      logic [11:0] fall_mv;
      logic [11:0] low_fall_mv;
   } obcd_lvd_cfg_t;
   typedef struct packed {
      obcd_flash_mode_t flash_mode;
      logic [5:0] max_main_mhz;
      logic [5:0] fast_osc_mhz;
      logic debug_allow;
      logic debug_erase_on_auth_fail;
   } obcd_sys_cfg_t;
endpackage

// ### logic/obcd_fetch.sv
`timescale 1ns/1ns
`default_nettype none
`include "obcd_consts.svh"
module obcd_fetch (
   input wire logic clk,
   input wire logic nrst,
   input wire logic boot_swap,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   output logic rd_req,
   output logic [19:0] rd_addr,
   output logic byte_we,
   output logic [1:0] byte_idx,
   output logic [7:0] byte_data,
   output logic done
);
   import obcd_pkg::*;
   obcd_fetch_st_t st_q, st_d;
   logic [19:0] addr_q, addr_d;
   logic [1:0] idx_q, idx_d;

   // Swap level is caught one edge after release, never under reset
   always_comb begin
      st_d = st_q;
      addr_d = addr_q;
      idx_d = idx_q;
      unique case (st_q)
         OBCD_F_SWAP: begin
            addr_d = boot_swap ? `OBCD_BASE_SWAP : `OBCD_BASE_NORMAL;
            st_d = OBCD_F_READ;
         end
         OBCD_F_READ: begin
            if (rd_valid) begin
               addr_d = addr_q + 20'h00001;
               idx_d = idx_q + 2'h1;
               if (idx_q == `OBCD_LAST_BYTE) begin
                  st_d = OBCD_F_DONE;
               end
            end
         end
         OBCD_F_DONE: begin
            st_d = OBCD_F_DONE;
         end
         default: begin
            st_d = OBCD_F_DONE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= OBCD_F_SWAP;
         addr_q <= `OBCD_BASE_NORMAL;
         idx_q <= 2'h0;
      end else begin
         st_q <= st_d;
         addr_q <= addr_d;
         idx_q <= idx_d;
      end
   end

   assign rd_req = (st_q == OBCD_F_READ);
   assign rd_addr = addr_q;
   assign byte_we = rd_req && rd_valid;
   assign byte_idx = idx_q;
   assign byte_data = rd_data;
   assign done = (st_q == OBCD_F_DONE);
endmodule
`default_nettype wire

// ### logic/obcd_lvd_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "obcd_consts.svh"
module obcd_lvd_decode (
   input wire logic [7:0] lvd_byte,
   output var obcd_pkg::obcd_lvd_cfg_t cfg,
   output logic bad
);
   import obcd_pkg::*;
   logic [2:0] grp;
   logic [1:0] lvl;
   logic [1:0] md;

   assign grp = lvd_byte[`OBCD_LVD_GRP_HI:`OBCD_LVD_GRP_LO];
   assign lvl = lvd_byte[`OBCD_LVD_LVL_HI:`OBCD_LVD_LVL_LO];
   assign md = lvd_byte[`OBCD_LVD_MODE_HI:`OBCD_LVD_MODE_LO];

   // Unlisted codes fall back to detection off and raise the flag
   always_comb begin
      cfg = '0;
      bad = !lvd_byte[`OBCD_LVD_FIX_BIT];
      if (grp[2] && md[0]) begin
         cfg.mode = OBCD_LVD_OFF;
      end else if (md == 2'b10) begin
         cfg.mode = OBCD_LVD_IRQ_RST;
         unique case ({grp, lvl})
            5'h02: cfg = {OBCD_LVD_IRQ_RST, 12'h6EA, 12'h6C2, 12'h65E};
            5'h01: cfg = {OBCD_LVD_IRQ_RST, 12'h758, 12'h730, 12'h65E};
            5'h00: cfg = {OBCD_LVD_IRQ_RST, 12'hB68, 12'hB2C, 12'h65E};
            5'h06: cfg = {OBCD_LVD_IRQ_RST, 12'h7BC, 12'h794, 12'h730};
            5'h05: cfg = {OBCD_LVD_IRQ_RST, 12'h82A, 12'h7F8, 12'h730};
            5'h04: cfg = {OBCD_LVD_IRQ_RST, 12'hC3A, 12'hBF4, 12'h730};
            5'h0A: cfg = {OBCD_LVD_IRQ_RST, 12'hA32, 12'h9F6, 12'h992};
            5'h09: cfg = {OBCD_LVD_IRQ_RST, 12'hA96, 12'hA5A, 12'h992};
            5'h0E: cfg = {OBCD_LVD_IRQ_RST, 12'hB68, 12'hB2C, 12'hABE};
            5'h0D: cfg = {OBCD_LVD_IRQ_RST, 12'hBCC, 12'hB90, 12'hABE};
            default: begin
               cfg.mode = OBCD_LVD_OFF;
               bad = 1'b1;
            end
         endcase
      end else if (md[0]) begin
         cfg.mode = md[1] ? OBCD_LVD_RST : OBCD_LVD_IRQ;
         unique case ({grp, lvl})
            5'h03: {cfg.rise_mv, cfg.fall_mv} = {12'h686, 12'h65E};
            5'h02: {cfg.rise_mv, cfg.fall_mv} = {12'h6EA, 12'h6C2};
            5'h07: {cfg.rise_mv, cfg.fall_mv} = {12'h758, 12'h730};
            5'h06: {cfg.rise_mv, cfg.fall_mv} = {12'h7BC, 12'h794};
            5'h05: {cfg.rise_mv, cfg.fall_mv} = {12'h82A, 12'h7F8};
            5'h0B: {cfg.rise_mv, cfg.fall_mv} = {12'h9C4, 12'h992};
            5'h0A: {cfg.rise_mv, cfg.fall_mv} = {12'hA32, 12'h9F6};
            5'h09: {cfg.rise_mv, cfg.fall_mv} = {12'hA96, 12'hA5A};
            5'h0F: {cfg.rise_mv, cfg.fall_mv} = {12'hAFA, 12'hABE};
            5'h0E: {cfg.rise_mv, cfg.fall_mv} = {12'hB68, 12'hB2C};
            5'h0D: {cfg.rise_mv, cfg.fall_mv} = {12'hBCC, 12'hB90};
            5'h04: {cfg.rise_mv, cfg.fall_mv} = {12'hC3A, 12'hBF4};
            default: begin
               cfg.mode = OBCD_LVD_OFF;
               bad = 1'b1;
            end
         endcase
      end else begin
         bad = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### logic/obcd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "obcd_consts.svh"
module obcd_decoder #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic CLK,
   input wire logic NRST,
   output logic FLASH_RD_REQ,
   output logic [19:0] FLASH_RD_ADDR,
   input wire logic FLASH_RD_VALID,
   input wire logic [7:0] FLASH_RD_DATA,
   input wire logic BOOT_SWAP,
   input wire logic STANDBY_STATE,
   input wire logic DEBUG_WR_VALID,
   input wire logic [2:0] DEBUG_WR_BITS,
   output logic CFG_READY,
   output logic CFG_BAD,
   output var obcd_pkg::obcd_wd_cfg_t WD_CFG,
   output logic WD_COUNT_ALLOW,
   output var obcd_pkg::obcd_lvd_cfg_t LVD_CFG,
   output var obcd_pkg::obcd_sys_cfg_t SYS_CFG,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   import obcd_pkg::*;

   // Fetch side
   logic fetch_we;
   logic [1:0] fetch_idx;
   logic [7:0] fetch_data;
   logic fetch_done;

   // Option byte store and latched decode
   logic [7:0] bytes_q [4];
   logic [7:0] bytes_d [4];
   logic ready_q, ready_d;
   obcd_wd_cfg_t wd_q, wd_d, wd_n;
   obcd_lvd_cfg_t lvd_q, lvd_d, lvd_n;
   obcd_sys_cfg_t sys_q, sys_d, sys_n;
   logic [4:0] bad_q, bad_d, bad_n;
   logic lvd_bad;

   // Watchdog gating and software control
   logic allow_q, allow_d;
   logic stby_req_q, stby_req_d;

   // Register bus state
   logic aw_full_q, aw_full_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic w_full_q, w_full_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [7:0] wr_idx;
   logic wr_in_page;
   logic wr_hit;
   logic [7:0] rd_idx;
   logic rd_in_page;
   logic rd_hit;
   logic [31:0] rd_word;

   obcd_fetch u_fetch (
      .clk(CLK),
      .nrst(NRST),
      .boot_swap(BOOT_SWAP),
      .rd_valid(FLASH_RD_VALID),
      .rd_data(FLASH_RD_DATA),
      .rd_req(FLASH_RD_REQ),
      .rd_addr(FLASH_RD_ADDR),
      .byte_we(fetch_we),
      .byte_idx(fetch_idx),
      .byte_data(fetch_data),
      .done(fetch_done)
   );

   obcd_lvd_decode u_lvd (
      .lvd_byte(bytes_q[1]),
      .cfg(lvd_n),
      .bad(lvd_bad)
   );

   // Watchdog byte decode
   always_comb begin
      wd_n = '0;
      bad_n[0] = 1'b0;
      wd_n.counter_run = bytes_q[0][`OBCD_WD_RUN_BIT];
      wd_n.standby_run = bytes_q[0][`OBCD_WD_STBY_BIT];
      wd_n.interval_irq_use = bytes_q[0][`OBCD_WD_IRQ_BIT];
      unique case (bytes_q[0][`OBCD_WD_OVF_HI:`OBCD_WD_OVF_LO])
         3'h0: wd_n.ovf_exp = 5'h06;
         3'h1: wd_n.ovf_exp = 5'h07;
         3'h2: wd_n.ovf_exp = 5'h08;
         3'h3: wd_n.ovf_exp = 5'h09;
         3'h4: wd_n.ovf_exp = 5'h0B;
         3'h5: wd_n.ovf_exp = 5'h0D;
         3'h6: wd_n.ovf_exp = 5'h0E;
         3'h7: wd_n.ovf_exp = 5'h10;
      endcase
      wd_n.ovf_cycles = 17'h00001 << wd_n.ovf_exp;
      // Three quarters of overflow; the extra half slow cycle is the
      // consumer's, since a whole-cycle count cannot hold it
      wd_n.irq_cycles = (wd_n.ovf_cycles >> 1) + (wd_n.ovf_cycles >> 2);
      unique case (bytes_q[0][`OBCD_WD_WIN_HI:`OBCD_WD_WIN_LO])
         2'h1: wd_n.open_pct = 7'h32;
         2'h2: wd_n.open_pct = 7'h4B;
         2'h3: wd_n.open_pct = 7'h64;
         2'h0: begin
            wd_n.open_pct = 7'h64;
            bad_n[0] = 1'b1;
         end
      endcase
      if (!wd_n.standby_run) begin
         wd_n.open_pct = 7'h64;
      end
   end

   // Flash mode, oscillator and debug byte decode
   always_comb begin
      sys_n = '0;
      bad_n[2] = !bytes_q[2][`OBCD_FM_ONE_BIT] ||
                 bytes_q[2][`OBCD_FM_ZERO_BIT];
      bad_n[3] = 1'b0;
      bad_n[4] = 1'b0;
      unique case (bytes_q[2][`OBCD_FM_MODE_HI:`OBCD_FM_MODE_LO])
         2'h0: begin
            sys_n.flash_mode = OBCD_LOW_VOLTAGE_MAIN;
            sys_n.max_main_mhz = 6'h04;
         end
         2'h2: begin
            sys_n.flash_mode = OBCD_LOW_SPEED_MAIN;
            sys_n.max_main_mhz = 6'h08;
         end
         2'h3: begin
            sys_n.flash_mode = OBCD_HIGH_SPEED_MAIN;
            sys_n.max_main_mhz = 6'h20;
         end
         2'h1: begin
            sys_n.flash_mode = OBCD_FLASH_MODE_BAD;
            sys_n.max_main_mhz = 6'h00;
            bad_n[2] = 1'b1;
         end
      endcase
      unique case (bytes_q[2][`OBCD_FM_FRQ_HI:`OBCD_FM_FRQ_LO])
         4'h8: sys_n.fast_osc_mhz = 6'h20;
         4'h0: sys_n.fast_osc_mhz = 6'h18;
         4'h9: sys_n.fast_osc_mhz = 6'h10;
         4'h1: sys_n.fast_osc_mhz = 6'h0C;
         4'hA: sys_n.fast_osc_mhz = 6'h08;
         4'h2: sys_n.fast_osc_mhz = 6'h06;
         4'hB: sys_n.fast_osc_mhz = 6'h04;
         4'h3: sys_n.fast_osc_mhz = 6'h03;
         4'hC: sys_n.fast_osc_mhz = 6'h02;
         4'hD: sys_n.fast_osc_mhz = 6'h01;
         default: begin
            sys_n.fast_osc_mhz = 6'h00;
            bad_n[3] = 1'b1;
         end
      endcase
      // Bits 3..1 may be rewritten by the debugger, so only 7..4 and 0 are checked
      if (bytes_q[3][`OBCD_DBG_FIX_HI:`OBCD_DBG_FIX_LO] != 3'h0) begin
         bad_n[4] = 1'b1;
      end
      unique case ({bytes_q[3][`OBCD_DBG_EN_BIT],
                    bytes_q[3][`OBCD_DBG_KEEP_BIT]})
         2'h2: begin
            sys_n.debug_allow = 1'b1;
            sys_n.debug_erase_on_auth_fail = 1'b1;
         end
         2'h3: begin
            sys_n.debug_allow = 1'b1;
            sys_n.debug_erase_on_auth_fail = 1'b0;
         end
         2'h1: begin
            sys_n.debug_allow = 1'b0;
            sys_n.debug_erase_on_auth_fail = 1'b0;
            bad_n[4] = 1'b1;
         end
         2'h0: begin
            sys_n.debug_allow = 1'b0;
            sys_n.debug_erase_on_auth_fail = 1'b0;
         end
      endcase
      bad_n[1] = lvd_bad;
   end

   // Byte capture, one-shot latch of decode, debugger overwrite of 3..1
   always_comb begin
      bytes_d = bytes_q;
      ready_d = ready_q;
      wd_d = wd_q;
      lvd_d = lvd_q;
      sys_d = sys_q;
      bad_d = bad_q;
      if (fetch_we) begin
         bytes_d[fetch_idx] = fetch_data;
      end
      if (fetch_done && !ready_q) begin
         ready_d = 1'b1;
         wd_d = wd_n;
         lvd_d = lvd_n;
         sys_d = sys_n;
         bad_d = bad_n;
      end
      if (ready_q && sys_q.debug_allow && DEBUG_WR_VALID) begin
         bytes_d[3][`OBCD_DBG_OVR_HI:`OBCD_DBG_OVR_LO] = DEBUG_WR_BITS;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < 4; i++) begin
            bytes_q[i] <= `OBCD_BYTE_RST;
         end
         ready_q <= 1'b0;
         wd_q <= '0;
         lvd_q <= '0;
         sys_q <= '0;
         bad_q <= 5'h00;
      end else begin
         bytes_q <= bytes_d;
         ready_q <= ready_d;
         wd_q <= wd_d;
         lvd_q <= lvd_d;
         sys_q <= sys_d;
         bad_q <= bad_d;
      end
   end

   // Counting permission; standby comes from the pin or from software
   always_comb begin
      allow_d = ready_q && wd_q.counter_run;
      if ((STANDBY_STATE || stby_req_q) && !wd_q.standby_run) begin
         allow_d = 1'b0;
      end else if (STANDBY_STATE || stby_req_q) begin
         allow_d = ready_q && wd_q.counter_run;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         allow_q <= 1'b0;
      end else begin
         allow_q <= allow_d;
      end
   end

   // Word index decode; the page above the index field must be zero
   assign wr_idx = awaddr_q[9:2];
   assign wr_in_page = (awaddr_q[ADDR_W-1:10] == '0);
   assign wr_hit = wr_in_page && (wr_idx >= `OBCD_IDX_WD) &&
                   (wr_idx <= `OBCD_IDX_CTRL);
   assign rd_idx = S_AXI_ARADDR[9:2];
   assign rd_in_page = (S_AXI_ARADDR[ADDR_W-1:10] == '0);
   assign rd_hit = rd_in_page && (rd_idx >= `OBCD_IDX_WD) &&
                   (rd_idx <= `OBCD_IDX_CTRL);

   // Read data mux, byte registers in the low lane
   always_comb begin
      rd_word = 32'h00000000;
      unique case (rd_idx)
         `OBCD_IDX_WD: rd_word[7:0] = bytes_q[0];
         `OBCD_IDX_LVD: rd_word[7:0] = bytes_q[1];
         `OBCD_IDX_FOSC: rd_word[7:0] = bytes_q[2];
         `OBCD_IDX_DBG: rd_word[7:0] = bytes_q[3];
         `OBCD_IDX_STAT: begin
            rd_word[4:0] = bad_q;
            rd_word[`OBCD_STAT_READY_BIT] = ready_q;
         end
         `OBCD_IDX_CTRL: rd_word[0] = stby_req_q;
         default: rd_word = 32'h00000000;
      endcase
   end

   // Write channel: address and data taken in either order, one
   // response at a time; read-only words accept and ignore writes
   always_comb begin
      aw_full_d = aw_full_q;
      awaddr_d = awaddr_q;
      w_full_d = w_full_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      stby_req_d = stby_req_q;
      if (S_AXI_AWVALID && !aw_full_q) begin
         aw_full_d = 1'b1;
         awaddr_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_full_q) begin
         w_full_d = 1'b1;
         wdata_d = S_AXI_WDATA;
         wstrb_d = S_AXI_WSTRB;
      end
      if (bvalid_q && S_AXI_BREADY) begin
         bvalid_d = 1'b0;
      end else if (aw_full_q && w_full_q && !bvalid_q) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? `OBCD_RESP_OKAY : `OBCD_RESP_DECERR;
         if (wr_hit && wr_idx == `OBCD_IDX_CTRL && wstrb_q[0]) begin
            stby_req_d = wdata_q[0];
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         aw_full_q <= 1'b0;
         awaddr_q <= '0;
         w_full_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `OBCD_RESP_OKAY;
         stby_req_q <= `OBCD_CTRL_RST;
      end else begin
         aw_full_q <= aw_full_d;
         awaddr_q <= awaddr_d;
         w_full_q <= w_full_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         stby_req_q <= stby_req_d;
      end
   end

   // Read channel: data registered, valid one cycle after the address
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && S_AXI_RREADY) begin
         rvalid_d = 1'b0;
      end else if (S_AXI_ARVALID && !rvalid_q) begin
         rvalid_d = 1'b1;
         rdata_d = rd_hit ? rd_word : 32'h00000000;
         rresp_d = rd_hit ? `OBCD_RESP_OKAY : `OBCD_RESP_DECERR;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `OBCD_RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // Outputs
   assign CFG_READY = ready_q;
   assign CFG_BAD = |bad_q;
   assign WD_CFG = wd_q;
   assign WD_COUNT_ALLOW = allow_q;
   assign LVD_CFG = lvd_q;
   assign SYS_CFG = sys_q;
   assign S_AXI_AWREADY = !aw_full_q;
   assign S_AXI_WREADY = !w_full_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = !rvalid_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
endmodule
`default_nettype wire

// ### tb/obcd_checker.sv
`timescale 1ns/1ns
`default_nettype none
module obcd_checker (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic FLASH_RD_REQ,
   input wire logic [19:0] FLASH_RD_ADDR,
   input wire logic FLASH_RD_VALID,
   input wire logic STANDBY_STATE,
   input wire logic CFG_READY,
   input wire logic WD_COUNT_ALLOW,
   input wire obcd_pkg::obcd_wd_cfg_t WD_CFG,
   input wire obcd_pkg::obcd_sys_cfg_t SYS_CFG
);
   import obcd_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   // Fetch protocol and address order
   a_req_hold: assert property (FLASH_RD_REQ && !FLASH_RD_VALID
      |=> FLASH_RD_REQ && $stable(FLASH_RD_ADDR)) else $error("fetch dropped");
   a_first_addr: assert property ($rose(FLASH_RD_REQ)
      |-> FLASH_RD_ADDR[11:0] == 12'h0C0) else $error("bad first address");
   a_addr_step: assert property (FLASH_RD_REQ && FLASH_RD_VALID
      && FLASH_RD_ADDR[1:0] != 2'h3 |=> FLASH_RD_ADDR ==
      $past(FLASH_RD_ADDR) + 20'h1) else $error("address not stepped");
   // Decoded values stay put once loaded and match the window and overflow rules
   a_ready_hold: assert property (CFG_READY |=> CFG_READY
      && !FLASH_RD_REQ && $stable(WD_CFG) && $stable(SYS_CFG))
      else $error("config not held");
   a_win_full: assert property (CFG_READY && !WD_CFG.standby_run
      |-> WD_CFG.open_pct == 7'h64) else $error("window not full");
   a_ovf_pow: assert property (CFG_READY |-> WD_CFG.ovf_cycles ==
      (17'h1 << WD_CFG.ovf_exp) && WD_CFG.irq_cycles == WD_CFG.ovf_cycles
      - (WD_CFG.ovf_cycles >> 2)) else $error("overflow count wrong");
   // Standby gating, one cycle late by design
   a_stby_stop: assert property (CFG_READY && STANDBY_STATE
      && !WD_CFG.standby_run |=> !WD_COUNT_ALLOW) else $error("ran in standby");
   a_stby_run: assert property (CFG_READY && WD_CFG.counter_run
      && WD_CFG.standby_run |=> WD_COUNT_ALLOW) else $error("counter halted");
   c_swap: cover property (FLASH_RD_REQ && FLASH_RD_ADDR[12]);
   c_stby: cover property (CFG_READY && STANDBY_STATE && WD_CFG.standby_run);
   c_slow: cover property (FLASH_RD_REQ && !FLASH_RD_VALID);
endmodule
bind obcd_decoder obcd_checker u_chk (.CLK, .NRST, .FLASH_RD_REQ,
   .FLASH_RD_ADDR, .FLASH_RD_VALID, .STANDBY_STATE, .CFG_READY,
   .WD_COUNT_ALLOW, .WD_CFG, .SYS_CFG);
`default_nettype wire

// ### tb/obcd_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module obcd_flash_model (
   input wire logic clk,
   input wire logic req,
   input wire logic [19:0] addr,
   input wire logic slow,
   output logic valid = 1'b0,
   output logic [7:0] data = 8'h00
);
   logic [7:0] mem_n [4];
   logic [7:0] mem_s [4];
   int wait_n = 0;
   // Idle data toggles so a stale byte never looks fresh
   always @(posedge clk) begin
      valid <= 1'b0;
      data <= ~data;
      if (req && !valid && wait_n >= (slow ? 3 : 0)) begin
         valid <= 1'b1;
         data <= addr[12] ? mem_s[addr[1:0]] : mem_n[addr[1:0]];
         wait_n <= 0;
      end else if (req && !valid) begin
         wait_n <= wait_n + 1;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import obcd_pkg::*;
   logic CLK = 1'b0, NRST = 1'b0, BOOT_SWAP = 1'b0, STANDBY_STATE = 1'b0;
   logic DEBUG_WR_VALID = 1'b0, slow = 1'b0;
   logic [2:0] DEBUG_WR_BITS = 3'h0;
   logic FLASH_RD_REQ, FLASH_RD_VALID, CFG_READY, CFG_BAD, WD_COUNT_ALLOW;
   logic [19:0] FLASH_RD_ADDR;
   logic [7:0] FLASH_RD_DATA;
   obcd_wd_cfg_t WD_CFG;
   obcd_lvd_cfg_t LVD_CFG;
   obcd_sys_cfg_t SYS_CFG;
   logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
   logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB = 4'hF;
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
   logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic [33:0] q[$];
   int n_errors = 0, check_count = 0;
   logic [7:0] ob[4];
   logic [3:0] frq[12] = '{4'h8, 4'h0, 4'h9, 4'h1, 4'hA, 4'h2, 4'hB, 4'h3,
      4'hC, 4'hD, 4'hE, 4'h4};
   logic [5:0] mhz[12] = '{6'h20, 6'h18, 6'h10, 6'h0C, 6'h08, 6'h06, 6'h04,
      6'h03, 6'h02, 6'h01, 6'h00, 6'h00};
   logic [7:0] lb[4] = '{8'h1A, 8'h1F, 8'h1D, 8'hF1};
   obcd_lvd_mode_t lm[4] = '{OBCD_LVD_IRQ_RST, OBCD_LVD_RST, OBCD_LVD_IRQ,
      OBCD_LVD_OFF};
   logic [11:0] lr[4] = '{12'h6EA, 12'h686, 12'h686, 12'h000};
   logic [1:0] fm[3] = '{2'h0, 2'h2, 2'h3};
   obcd_flash_mode_t fe[3] = '{OBCD_LOW_VOLTAGE_MAIN, OBCD_LOW_SPEED_MAIN,
      OBCD_HIGH_SPEED_MAIN};
   logic [1:0] dg[3] = '{2'h0, 2'h2, 2'h3};
   logic [1:0] de[3] = '{2'h0, 2'h3, 2'h2};
   logic [4:0] ovf[8] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0B, 5'h0D, 5'h0E,
      5'h10};
   logic [6:0] win[4] = '{7'h64, 7'h32, 7'h4B, 7'h64};
   obcd_decoder u_dut (.*);
   obcd_flash_model u_flash (.clk(CLK), .req(FLASH_RD_REQ),
      .addr(FLASH_RD_ADDR), .slow(slow), .valid(FLASH_RD_VALID),
      .data(FLASH_RD_DATA));
   always #5 CLK = ~CLK;
   // Random standby keeps the watchdog gating busy all run long
   always @(posedge CLK) STANDBY_STATE <= 1'($urandom);
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Readies sampled mid-cycle, where they match the next edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w;
      @(posedge CLK);
      q.push_back(34'h0);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      while (S_AXI_AWVALID || S_AXI_WVALID) begin
         @(negedge CLK);
         aw = S_AXI_AWREADY;
         w = S_AXI_WREADY;
         @(posedge CLK);
         if (aw) S_AXI_AWVALID <= 1'b0;
         if (w) S_AXI_WVALID <= 1'b0;
      end
      do @(negedge CLK); while (!S_AXI_BVALID);
      @(posedge CLK);
      S_AXI_BREADY <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      @(posedge CLK);
      q.push_back(e);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do @(negedge CLK); while (!S_AXI_ARREADY);
      @(posedge CLK);
      S_AXI_ARVALID <= 1'b0;
      do @(negedge CLK); while (!S_AXI_RVALID);
      @(posedge CLK);
      S_AXI_RREADY <= 1'b0;
   endtask
   // Each bus answer against the oldest note
   always @(negedge CLK) begin
      if (S_AXI_RVALID && S_AXI_RREADY) chk({S_AXI_RRESP, S_AXI_RDATA},
         q.pop_front());
      if (S_AXI_BVALID && S_AXI_BREADY) chk({S_AXI_BRESP, 32'h0},
         q.pop_front());
   end
   // Inactive area holds inverted bytes, so a wrong area shows at once
   initial begin
      int i;
      int n;
      void'($urandom(32'h2A79));
      for (i = 0; i < 12; i++) begin
         ob[0] = 8'($urandom);
         ob[1] = lb[i % 4];
         ob[2] = {fm[i % 3], 2'b10, frq[i]};
         ob[3] = {dg[i % 3][1], 6'b000010, dg[i % 3][0]};
         for (n = 0; n < 4; n++) begin
            u_flash.mem_n[n] = i[0] ? ~ob[n] : ob[n];
            u_flash.mem_s[n] = i[0] ? ob[n] : ~ob[n];
         end
         @(posedge CLK);
         NRST <= 1'b0;
         BOOT_SWAP <= i[0];
         slow <= i[1];
         repeat (8) @(posedge CLK);
         NRST <= 1'b1;
         n = 0;
         while (!CFG_READY && n < 60) begin
            @(negedge CLK);
            n++;
         end
         chk(CFG_READY, 1'b1);
         chk(WD_CFG.ovf_exp, ovf[ob[0][3:1]]);
         chk(WD_CFG.irq_cycles, 17'h3 << (ovf[ob[0][3:1]] - 2));
         chk(WD_CFG.open_pct, ob[0][0] ? win[ob[0][6:5]] : 7'h64);
         chk(LVD_CFG.mode, lm[i % 4]);
         chk(LVD_CFG.rise_mv, lr[i % 4]);
         chk(SYS_CFG.flash_mode, fe[i % 3]);
         chk(SYS_CFG.fast_osc_mhz, mhz[i]);
         chk({SYS_CFG.debug_allow, SYS_CFG.debug_erase_on_auth_fail},
            de[i % 3]);
         chk(CFG_BAD, i > 9 || ob[0][6:5] == 2'b00);
         wr(12'h300, 32'($urandom));
         for (n = 0; n < 4; n++) rd(12'h300 + 12'(4 * n), {26'h0, ob[n]});
         rd(12'h400, {2'h3, 32'h0});
      end
      conclude;
   end
   initial begin
      #100000;
      n_errors++;
      conclude;
   end
endmodule
`default_nettype wire
